// >>> rtl/lcrs_pkg.sv
// Shared constants and carrier types for the loop-code and receive alarm status block.
package lcrs_pkg;

  // Persistence time for loop codes, in seconds, and the clock rate in hertz.
  localparam int unsigned CLK_HZ = 200000000;
  localparam int unsigned PERSIST_S = 5;
  localparam int unsigned PERSIST_CYC = PERSIST_S * CLK_HZ;
  localparam int CNT_W = 30;

  // Avalon-MM slave geometry and register byte offsets.
  localparam int AW = 4;
  localparam int DW = 32;
  localparam logic [AW-1:0] OFF_CTRL = 4'h0;
  localparam logic [AW-1:0] OFF_IRQ_EN = 4'h4;
  localparam logic [AW-1:0] OFF_STATUS = 4'h8;
  localparam logic [AW-1:0] OFF_IRQ_STAT = 4'hc;

  // Bit positions shared by status, interrupt status and interrupt enable; B_RLB is in status only.
  localparam int NSRC = 4;
  localparam int B_QRSS = 0;
  localparam int B_LOS = 1;
  localparam int B_AIS = 2;
  localparam int B_LCD = 3;
  localparam int B_RLB = 4;
  localparam logic [NSRC-1:0] SRC_NONE = 4'h0;

  // Control register fields.
  localparam int B_MODE_LO = 0;
  localparam int B_MODE_HI = 1;
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_AUTO = 2'h3;

  // Loop-up code is one mark in five bits, loop-down code one mark in three.
  localparam int UP_LEN = 5;
  localparam int DN_LEN = 3;
  localparam int WIN_W = 2 * UP_LEN;

  typedef enum logic [1:0] {
    LC_OFF = 2'b00,
    LC_MANUAL = 2'b01,
    LC_AUTO_UP = 2'b10,
    LC_AUTO_DN = 2'b11
  } lcrs_lc_e;

  typedef struct packed {
    logic read;
    logic write;
    logic [AW-1:0] address;
    logic [DW-1:0] writedata;
  } lcrs_avs_req_s;

  typedef struct packed {
    logic [DW-1:0] readdata;
    logic waitrequest;
  } lcrs_avs_rsp_s;

  typedef struct packed {
    logic bit_val;
    logic bit_en;
    logic ais;
    logic los;
    logic qrss;
  } lcrs_rx_s;

  typedef struct packed {
    logic [WIN_W-1:0] win;
    logic up_seen;
    logic dn_seen;
  } lcrs_det_s;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic expired;
  } lcrs_cnt_s;

  typedef struct packed {
    lcrs_lc_e lc;
    logic [1:0] mode;
    logic [NSRC-1:0] en;
    logic [NSRC-1:0] stat;
    logic [NSRC-1:0] clr;
    logic lcd;
    logic ais;
    logic los;
    logic qrss;
    logic lb;
    logic wait_r;
    logic [DW-1:0] rdata;
    logic irq;
  } lcrs_main_s;

endpackage

// >>> rtl/lcrs_code_det.sv
// Recogniser for the repeating loop-up and loop-down codes in received data.
`timescale 1ns/1ps
module lcrs_code_det (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic rx_bit,
  input wire logic rx_bit_en,
  output logic up_seen,
  output logic dn_seen
);

  lcrs_pkg::lcrs_det_s st_r;
  lcrs_pkg::lcrs_det_s st_nxt;

  // True when exactly one bit of the group is a mark.
  function automatic logic one_mark(input logic [lcrs_pkg::UP_LEN-1:0] v);
    one_mark = (v != '0) && ((v & (v - 1'b1)) == '0);
  endfunction

  always_comb begin
    logic [lcrs_pkg::WIN_W-1:0] w;
    w = st_r.win;
    st_nxt = st_r;
    if (rx_bit_en) begin
      w = {st_r.win[lcrs_pkg::WIN_W-2:0], rx_bit};
    end
    st_nxt.win = w;
    // A code counts as present only once two whole periods repeat exactly.
    st_nxt.up_seen = (w[2*lcrs_pkg::UP_LEN-1:lcrs_pkg::UP_LEN] == w[lcrs_pkg::UP_LEN-1:0])
                     && one_mark(w[lcrs_pkg::UP_LEN-1:0]);
    st_nxt.dn_seen = (w[2*lcrs_pkg::DN_LEN-1:lcrs_pkg::DN_LEN] == w[lcrs_pkg::DN_LEN-1:0])
                     && one_mark({2'h0, w[lcrs_pkg::DN_LEN-1:0]});
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign up_seen = st_r.up_seen;
  assign dn_seen = st_r.dn_seen;

endmodule

// >>> rtl/lcrs_persist.sv
// Persistence timer: reports when its input has held longer than a limit.
`timescale 1ns/1ps
module lcrs_persist #(
  parameter int unsigned LIMIT = lcrs_pkg::PERSIST_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic active,
  output logic expired
);

  localparam logic [lcrs_pkg::CNT_W-1:0] LIM = LIMIT[lcrs_pkg::CNT_W-1:0];

  lcrs_pkg::lcrs_cnt_s st_r;
  lcrs_pkg::lcrs_cnt_s st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (!active) begin
      st_nxt = '0;
    end else if (st_r.cnt != LIM) begin
      st_nxt.cnt = st_r.cnt + 1'b1;
    end else begin
      st_nxt.expired = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign expired = st_r.expired;

  chk_count_restart: assert property (@(posedge mclk) disable iff (!rst_n)
    !active |=> (st_r.cnt == '0) && !expired)
    else $error("Persistence count did not restart when the code stopped.");

  chk_expire_late: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(expired) |-> $past(st_r.cnt) == LIM && $past(active))
    else $error("Persistence expired before the limit was exceeded.");

endmodule

// >>> rtl/lcrs_top.sv
// Loop-code detection and receive alarm status for one line channel.
// Behaviour
// - Manual mode sets detected flag after loop-up or loop-down code persists past 5 s.
// - Manual mode: flag stays while code arrives, clears as soon as it stops.
// - Manual mode: every rise and fall of the flag raises a loop-code interrupt.
// - Selecting automatic mode clears the flag and watches for the loop-up code.
// - Automatic: loop-up past 5 s sets flag, starts remote loop-back, watches loop-down.
// - Automatic: flag stays high throughout remote loop-back even without loop-up code.
// - Automatic: loop-down past 5 s ends loop-back, clears flag, raises interrupt.
// - Automatic: every change of the detected flag raises an interrupt.
// - All-ones alarm flag follows the all-ones detector, read only.
// - All-ones alarm interrupt on any transition when its enable is set.
// - Signal-lost flag follows the receive input absence, read only.
// - Signal-lost interrupt on any transition when its enable is set.
// - Pattern-lock flag follows the test pattern synchroniser, read only.
// - Pattern-lock interrupt on any transition when its enable is set.
// - Each flag has a sticky interrupt status bit, set on change, cleared by read.
// - Per-source interrupt enable bits reset to zero; one enables, zero masks.
//
// Local design decisions: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module lcrs_top #(
  parameter int unsigned PERSIST_CYC = lcrs_pkg::PERSIST_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  input lcrs_pkg::lcrs_avs_req_s avs_req,
  output lcrs_pkg::lcrs_avs_rsp_s avs_rsp,
  input lcrs_pkg::lcrs_rx_s rx,
  output logic remote_loopback,
  output logic irq
);

  lcrs_pkg::lcrs_main_s st_r;
  lcrs_pkg::lcrs_main_s st_nxt;

  logic up_seen;
  logic dn_seen;
  logic up_act;
  logic dn_act;
  logic up_exp;
  logic dn_exp;
  logic manual_sel;

  lcrs_code_det u_det (
    .mclk(mclk),
    .rst_n(rst_n),
    .rx_bit(rx.bit_val),
    .rx_bit_en(rx.bit_en),
    .up_seen(up_seen),
    .dn_seen(dn_seen)
  );

  // Each timer only runs while its code is the one being watched, so a stale
  // expiry can never carry over from the other half of the automatic cycle.
  // The switch into automatic mode also stops both timers for a cycle, so a code
  // that persisted under manual mode is timed again from zero.
  assign manual_sel = (st_r.mode != lcrs_pkg::MODE_OFF) && (st_r.mode != lcrs_pkg::MODE_AUTO);
  assign up_act = up_seen && ((manual_sel && (st_r.lc == lcrs_pkg::LC_MANUAL)) ||
                              (st_r.lc == lcrs_pkg::LC_AUTO_UP));
  assign dn_act = dn_seen && ((manual_sel && (st_r.lc == lcrs_pkg::LC_MANUAL)) ||
                              (st_r.lc == lcrs_pkg::LC_AUTO_DN));

  lcrs_persist #(
    .LIMIT(PERSIST_CYC)
  ) u_up_timer (
    .mclk(mclk),
    .rst_n(rst_n),
    .active(up_act),
    .expired(up_exp)
  );

  lcrs_persist #(
    .LIMIT(PERSIST_CYC)
  ) u_dn_timer (
    .mclk(mclk),
    .rst_n(rst_n),
    .active(dn_act),
    .expired(dn_exp)
  );

  always_comb begin
    logic req_any;
    logic acc_rd;
    logic acc_wr;
    logic [lcrs_pkg::NSRC-1:0] chg;
    logic [lcrs_pkg::NSRC-1:0] w1c;
    logic [lcrs_pkg::NSRC-1:0] rdc;
    logic [lcrs_pkg::DW-1:0] rd;
    req_any = avs_req.read || avs_req.write;
    acc_rd = avs_req.read && !st_r.wait_r;
    acc_wr = avs_req.write && !st_r.wait_r;
    w1c = lcrs_pkg::SRC_NONE;
    rdc = lcrs_pkg::SRC_NONE;
    rd = '0;
    st_nxt = st_r;

    // Bus side: waitrequest drops for exactly one cycle after a request is seen.
    st_nxt.wait_r = !(req_any && st_r.wait_r);
    if (acc_wr) begin
      case (avs_req.address)
        lcrs_pkg::OFF_CTRL: begin
          st_nxt.mode = avs_req.writedata[lcrs_pkg::B_MODE_HI:lcrs_pkg::B_MODE_LO];
        end
        lcrs_pkg::OFF_IRQ_EN: begin
          st_nxt.en = avs_req.writedata[lcrs_pkg::NSRC-1:0];
        end
        lcrs_pkg::OFF_IRQ_STAT: begin
          w1c = avs_req.writedata[lcrs_pkg::NSRC-1:0];
        end
        default: begin
        end
      endcase
    end
    // Only the bits returned to software are cleared, so an event that lands
    // between sampling and completion is kept for the next read.
    if (acc_rd) begin
      rdc = st_r.clr;
    end
    if (req_any && st_r.wait_r) begin
      case (avs_req.address)
        lcrs_pkg::OFF_CTRL: begin
          rd[lcrs_pkg::B_MODE_HI:lcrs_pkg::B_MODE_LO] = st_r.mode;
        end
        lcrs_pkg::OFF_IRQ_EN: begin
          rd[lcrs_pkg::NSRC-1:0] = st_r.en;
        end
        lcrs_pkg::OFF_STATUS: begin
          rd[lcrs_pkg::B_LCD] = st_r.lcd;
          rd[lcrs_pkg::B_AIS] = st_r.ais;
          rd[lcrs_pkg::B_LOS] = st_r.los;
          rd[lcrs_pkg::B_QRSS] = st_r.qrss;
          rd[lcrs_pkg::B_RLB] = st_r.lb;
        end
        lcrs_pkg::OFF_IRQ_STAT: begin
          rd[lcrs_pkg::NSRC-1:0] = st_r.stat;
        end
        default: begin
        end
      endcase
      st_nxt.rdata = rd;
      st_nxt.clr = (avs_req.read && avs_req.address == lcrs_pkg::OFF_IRQ_STAT) ?
                   st_r.stat : lcrs_pkg::SRC_NONE;
    end

    // Alarm flags mirror their detectors.
    st_nxt.ais = rx.ais;
    st_nxt.los = rx.los;
    st_nxt.qrss = rx.qrss;

    // Loop-code flag and remote loop-back.
    if (st_r.mode == lcrs_pkg::MODE_AUTO) begin
      case (st_r.lc)
        lcrs_pkg::LC_AUTO_UP: begin
          if (up_exp) begin
            st_nxt.lc = lcrs_pkg::LC_AUTO_DN;
            st_nxt.lcd = 1'b1;
            st_nxt.lb = 1'b1;
          end
        end
        lcrs_pkg::LC_AUTO_DN: begin
          // The flag holds while loop-back stands, whatever the line sends.
          if (dn_exp) begin
            st_nxt.lc = lcrs_pkg::LC_AUTO_UP;
            st_nxt.lcd = 1'b0;
            st_nxt.lb = 1'b0;
          end
        end
        default: begin
          st_nxt.lc = lcrs_pkg::LC_AUTO_UP;
          st_nxt.lcd = 1'b0;
          st_nxt.lb = 1'b0;
        end
      endcase
    end else if (st_r.mode == lcrs_pkg::MODE_OFF) begin
      st_nxt.lc = lcrs_pkg::LC_OFF;
      st_nxt.lcd = 1'b0;
      st_nxt.lb = 1'b0;
    end else begin
      st_nxt.lc = lcrs_pkg::LC_MANUAL;
      st_nxt.lcd = up_exp || dn_exp;
      st_nxt.lb = 1'b0;
    end

    // Sticky change bits; a new change wins over a clear in the same cycle.
    chg[lcrs_pkg::B_LCD] = st_nxt.lcd != st_r.lcd;
    chg[lcrs_pkg::B_AIS] = st_nxt.ais != st_r.ais;
    chg[lcrs_pkg::B_LOS] = st_nxt.los != st_r.los;
    chg[lcrs_pkg::B_QRSS] = st_nxt.qrss != st_r.qrss;
    st_nxt.stat = (st_r.stat & ~(w1c | rdc)) | chg;
    // A change in the cycle that captures the read data is not in them, so it is kept.
    st_nxt.clr = st_nxt.clr & ~chg;
    st_nxt.irq = |(st_nxt.stat & st_nxt.en);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
      st_r.wait_r <= 1'b1;
      st_r.lc <= lcrs_pkg::LC_OFF;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign avs_rsp.readdata = st_r.rdata;
  assign avs_rsp.waitrequest = st_r.wait_r;
  assign remote_loopback = st_r.lb;
  assign irq = st_r.irq;

  chk_manual_follow: assert property (@(posedge mclk) disable iff (!rst_n)
    (manual_sel && st_r.lc == lcrs_pkg::LC_MANUAL) |=> st_r.lcd == $past(up_exp || dn_exp))
    else $error("Manual loop-code flag does not follow the persisted code.");

  chk_manual_set: assert property (@(posedge mclk) disable iff (!rst_n)
    (manual_sel && $rose(dn_exp)) |=> st_r.lcd)
    else $error("Manual loop-code flag not set after loop-down code persisted.");

  chk_off_quiet: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_r.mode == lcrs_pkg::MODE_OFF) |=> !st_r.lcd && !st_r.lb)
    else $error("Loop-code flag or loop-back active with detection off.");

  chk_auto_entry: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_r.mode == lcrs_pkg::MODE_AUTO && st_r.lc == lcrs_pkg::LC_MANUAL)
    |=> !st_r.lcd && st_r.lc == lcrs_pkg::LC_AUTO_UP)
    else $error("Entering automatic mode did not clear the loop-code flag.");

  chk_auto_loop_set: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_r.mode == lcrs_pkg::MODE_AUTO && st_r.lc == lcrs_pkg::LC_AUTO_UP && up_exp)
    |=> st_r.lcd && st_r.lb && st_r.lc == lcrs_pkg::LC_AUTO_DN)
    else $error("Loop-up persistence did not start remote loop-back.");

  chk_flag_during_lb: assert property (@(posedge mclk) disable iff (!rst_n)
    st_r.lb |-> st_r.lcd && st_r.lc == lcrs_pkg::LC_AUTO_DN)
    else $error("Loop-code flag low while remote loop-back is active.");

  chk_auto_loop_end: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_r.mode == lcrs_pkg::MODE_AUTO && st_r.lc == lcrs_pkg::LC_AUTO_DN && dn_exp)
    |=> !st_r.lcd && !st_r.lb && st_r.stat[lcrs_pkg::B_LCD])
    else $error("Loop-down persistence did not end remote loop-back.");

  chk_lcd_change_irq: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_r.lcd != $past(st_r.lcd) && st_r.en[lcrs_pkg::B_LCD]) |=> irq)
    else $error("Loop-code flag change raised no interrupt.");

  chk_alarm_follow: assert property (@(posedge mclk) disable iff (!rst_n)
    ##1 st_r.ais == $past(rx.ais) && st_r.los == $past(rx.los) && st_r.qrss == $past(rx.qrss))
    else $error("Alarm flags do not follow their detectors.");

  chk_ais_irq: assert property (@(posedge mclk) disable iff (!rst_n)
    ($changed(rx.ais) && st_r.en[lcrs_pkg::B_AIS]) ##1 st_r.en[lcrs_pkg::B_AIS] |=> irq)
    else $error("All-ones alarm change raised no interrupt.");

  chk_los_irq: assert property (@(posedge mclk) disable iff (!rst_n)
    ($changed(rx.los) && st_r.en[lcrs_pkg::B_LOS]) ##1 st_r.en[lcrs_pkg::B_LOS] |=> irq)
    else $error("Signal-lost change raised no interrupt.");

  chk_qrss_irq: assert property (@(posedge mclk) disable iff (!rst_n)
    ($changed(rx.qrss) && st_r.en[lcrs_pkg::B_QRSS]) ##1 st_r.en[lcrs_pkg::B_QRSS] |=> irq)
    else $error("Pattern-lock change raised no interrupt.");

  chk_masked_quiet: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_r.en == lcrs_pkg::SRC_NONE) |-> !irq)
    else $error("Interrupt raised with every source masked.");

  chk_read_clear: assert property (@(posedge mclk) disable iff (!rst_n)
    (avs_req.read && !st_r.wait_r && avs_req.address == lcrs_pkg::OFF_IRQ_STAT &&
     st_r.clr[lcrs_pkg::B_AIS] && st_nxt.ais == st_r.ais) |=> !st_r.stat[lcrs_pkg::B_AIS])
    else $error("Reading interrupt status did not clear the returned bit.");

  chk_manual_rise: assert property (@(posedge mclk) disable iff (!rst_n)
    (manual_sel && !st_r.lcd && (up_exp || dn_exp)) |=> st_r.lcd && st_r.stat[lcrs_pkg::B_LCD])
    else $error("Manual loop-code rise left no interrupt status.");

  chk_manual_fall: assert property (@(posedge mclk) disable iff (!rst_n)
    (manual_sel && st_r.lcd && !up_exp && !dn_exp) |=> !st_r.lcd && st_r.stat[lcrs_pkg::B_LCD])
    else $error("Manual loop-code flag did not fall when the code stopped.");

  chk_manual_no_lb: assert property (@(posedge mclk) disable iff (!rst_n)
    manual_sel |=> !st_r.lb)
    else $error("Remote loop-back active in manual mode.");

  chk_up_watch_idle: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_r.mode == lcrs_pkg::MODE_AUTO && st_r.lc == lcrs_pkg::LC_AUTO_UP && !up_exp)
    |=> !st_r.lcd && !st_r.lb && st_r.lc == lcrs_pkg::LC_AUTO_UP)
    else $error("Loop-up watch left before the loop-up code persisted.");

  chk_lb_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_r.mode == lcrs_pkg::MODE_AUTO && st_r.lb && !dn_exp) |=> st_r.lb && st_r.lcd)
    else $error("Remote loop-back dropped before the loop-down code persisted.");

  chk_auto_rise_irq: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_r.mode == lcrs_pkg::MODE_AUTO && st_r.lc == lcrs_pkg::LC_AUTO_UP && up_exp &&
     st_r.en[lcrs_pkg::B_LCD] && !avs_req.write) |=> irq)
    else $error("Start of remote loop-back raised no interrupt.");

  chk_lcd_change_stat: assert property (@(posedge mclk) disable iff (!rst_n)
    $changed(st_r.lcd) |-> st_r.stat[lcrs_pkg::B_LCD])
    else $error("Loop-code flag change left no interrupt status.");

  chk_flag_change_stat: assert property (@(posedge mclk) disable iff (!rst_n)
    (!$changed(st_r.ais) || st_r.stat[lcrs_pkg::B_AIS]) &&
    (!$changed(st_r.los) || st_r.stat[lcrs_pkg::B_LOS]) &&
    (!$changed(st_r.qrss) || st_r.stat[lcrs_pkg::B_QRSS]))
    else $error("Alarm flag change left no interrupt status.");

  chk_status_data: assert property (@(posedge mclk) disable iff (!rst_n)
    (avs_req.read && st_r.wait_r && avs_req.address == lcrs_pkg::OFF_STATUS)
    |=> avs_rsp.readdata[lcrs_pkg::B_AIS] == $past(st_r.ais) &&
        avs_rsp.readdata[lcrs_pkg::B_LOS] == $past(st_r.los) &&
        avs_rsp.readdata[lcrs_pkg::B_QRSS] == $past(st_r.qrss) &&
        avs_rsp.readdata[lcrs_pkg::B_LCD] == $past(st_r.lcd) &&
        avs_rsp.readdata[lcrs_pkg::B_RLB] == $past(st_r.lb))
    else $error("Status read returned flags other than those standing.");

  chk_stat_data: assert property (@(posedge mclk) disable iff (!rst_n)
    (avs_req.read && st_r.wait_r && avs_req.address == lcrs_pkg::OFF_IRQ_STAT)
    |=> avs_rsp.readdata[lcrs_pkg::NSRC-1:0] == $past(st_r.stat))
    else $error("Interrupt status read returned other bits than those standing.");

  chk_irq_level: assert property (@(posedge mclk) disable iff (!rst_n)
    irq == |(st_r.stat & st_r.en))
    else $error("Interrupt line differs from the enabled status bits.");

  chk_enable_write: assert property (@(posedge mclk) disable iff (!rst_n)
    (avs_req.write && !st_r.wait_r && avs_req.address == lcrs_pkg::OFF_IRQ_EN)
    |=> st_r.en == $past(avs_req.writedata[lcrs_pkg::NSRC-1:0]))
    else $error("Interrupt enable write did not land.");

  chk_mode_write: assert property (@(posedge mclk) disable iff (!rst_n)
    (avs_req.write && !st_r.wait_r && avs_req.address == lcrs_pkg::OFF_CTRL)
    |=> st_r.mode == $past(avs_req.writedata[lcrs_pkg::B_MODE_HI:lcrs_pkg::B_MODE_LO]))
    else $error("Mode write did not land.");

  chk_off_state: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_r.mode == lcrs_pkg::MODE_OFF) |=> st_r.lc == lcrs_pkg::LC_OFF)
    else $error("Loop-code state left idle with detection off.");

  cov_auto_enter_lb: cover property (@(posedge mclk) disable iff (!rst_n) $rose(st_r.lb));
  cov_auto_leave_lb: cover property (@(posedge mclk) disable iff (!rst_n) $fell(st_r.lb));
  cov_manual_flag: cover property (@(posedge mclk) disable iff (!rst_n) manual_sel ##1 $rose(st_r.lcd));
  cov_manual_drop: cover property (@(posedge mclk) disable iff (!rst_n) manual_sel ##1 $fell(st_r.lcd));
  cov_stat_read: cover property (@(posedge mclk) disable iff (!rst_n)
    avs_req.read && !st_r.wait_r && st_r.clr != lcrs_pkg::SRC_NONE);

endmodule

// >>> bench/lcrs_line_model.sv
// Far-end line equipment that streams loop-up, loop-down or idle all-ones data.
`timescale 1ns/1ps
module lcrs_line_model (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [1:0] code,
  output logic bit_val,
  output logic bit_en
);
  logic [2:0] ph;
  logic [2:0] last;
  // Code 1 sends one mark in five bits, code 2 one mark in three, anything else all ones.
  assign last = (code == 2'h2) ? 3'h2 : 3'h4;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ph <= 3'h0;
      bit_en <= 1'b0;
      bit_val <= 1'b1;
    end else if (!bit_en) begin
      bit_en <= 1'b1;
      bit_val <= (code == 2'h0) | (code == 2'h3) | (ph == last);
      ph <= (ph >= last) ? 3'h0 : ph + 3'h1;
    end else begin
      // Between strobes the data line toggles, so a stale bit is never mistaken for data.
      bit_en <= 1'b0;
      bit_val <= ~bit_val;
    end
  end
endmodule

// >>> bench/lcrs_top_test.sv
// Register-level bench for the loop-code and receive alarm status block.
`timescale 1ns/1ps
module lcrs_top_test;
  localparam int unsigned P = 20;
  localparam int LONG = 5 * P + 50;
  logic mclk;
  logic rst_n;
  lcrs_pkg::lcrs_avs_req_s req;
  lcrs_pkg::lcrs_avs_rsp_s rsp;
  lcrs_pkg::lcrs_rx_s rx;
  logic lv;
  logic le;
  logic [2:0] al;
  logic [1:0] code;
  logic rlb;
  logic irq;
  logic [31:0] d;
  int err_count;
  int compares;

  assign rx = {lv, le, al[2], al[1], al[0]};

  lcrs_top #(.PERSIST_CYC(P)) u_dut (
    .mclk(mclk),
    .rst_n(rst_n),
    .avs_req(req),
    .avs_rsp(rsp),
    .rx(rx),
    .remote_loopback(rlb),
    .irq(irq)
  );

  lcrs_line_model u_line (
    .mclk(mclk),
    .rst_n(rst_n),
    .code(code),
    .bit_val(lv),
    .bit_en(le)
  );

  always #2.5 mclk = ~mclk;

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One Avalon access; the request stands until waitrequest is sampled low.
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    req.read <= ~w;
    req.write <= w;
    req.address <= a;
    req.writedata <= wd;
    do begin
      @(posedge mclk);
      n++;
    end while (rsp.waitrequest !== 1'b0 && n < 50);
    d = rsp.readdata;
    req.read <= 1'b0;
    req.write <= 1'b0;
    if (n >= 50) chk(1'b0, 1'b1, "bus answer");
    @(posedge mclk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] wd);
    acc(1'b1, a, wd);
  endtask

  task automatic rdc(input logic [3:0] a, input logic [31:0] exp, input string what);
    acc(1'b0, a, 32'h0);
    chk(d, exp, what);
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    rst_n = 1'b0;
    req = '0;
    al = 3'h0;
    code = 2'h0;
    err_count = 0;
    compares = 0;
    cyc(2);
    rst_n <= 1'b1;
    cyc(1);
    rdc(lcrs_pkg::OFF_CTRL, 32'h0, "ctrl reset");
    rdc(lcrs_pkg::OFF_IRQ_EN, 32'h0, "enable reset");
    rdc(lcrs_pkg::OFF_IRQ_STAT, 32'h0, "irq status reset");
    wr(lcrs_pkg::OFF_STATUS, 32'hffffffff);
    rdc(lcrs_pkg::OFF_STATUS, 32'h0, "status read only");
    rdc(4'h1, 32'h0, "unmapped");
    chk(irq, 1'b0, "irq reset");
    $display("test reset done");

    for (int b = 0; b < 3; b++) begin
      al[b] <= 1'b1;
      cyc(3);
      rdc(lcrs_pkg::OFF_STATUS, 32'h1 << b, "alarm flag high");
      chk(irq, 1'b0, "masked irq");
      rdc(lcrs_pkg::OFF_IRQ_STAT, 32'h1 << b, "alarm rise");
      rdc(lcrs_pkg::OFF_IRQ_STAT, 32'h0, "cleared by read");
      wr(lcrs_pkg::OFF_IRQ_EN, 32'h1 << b);
      rdc(lcrs_pkg::OFF_IRQ_EN, 32'h1 << b, "enable set");
      al[b] <= 1'b0;
      cyc(3);
      rdc(lcrs_pkg::OFF_STATUS, 32'h0, "alarm flag low");
      chk(irq, 1'b1, "alarm fall irq");
      rdc(lcrs_pkg::OFF_IRQ_STAT, 32'h1 << b, "alarm fall");
      cyc(2);
      chk(irq, 1'b0, "irq after clear");
      wr(lcrs_pkg::OFF_IRQ_EN, 32'h0);
    end
    $display("test alarms done");

    wr(lcrs_pkg::OFF_CTRL, 32'h1);
    rdc(lcrs_pkg::OFF_CTRL, 32'h1, "mode readback");
    acc(1'b0, lcrs_pkg::OFF_IRQ_STAT, 32'h0);
    code <= 2'h1;
    cyc(P);
    rdc(lcrs_pkg::OFF_STATUS, 32'h0, "not yet persisted");
    cyc(LONG);
    rdc(lcrs_pkg::OFF_STATUS, 32'h8, "manual loop-up");
    chk(rlb, 1'b0, "manual no loopback");
    rdc(lcrs_pkg::OFF_IRQ_STAT, 32'h8, "manual rise");
    code <= 2'h0;
    cyc(30);
    rdc(lcrs_pkg::OFF_STATUS, 32'h0, "manual drop");
    rdc(lcrs_pkg::OFF_IRQ_STAT, 32'h8, "manual fall");
    code <= 2'h2;
    wr(lcrs_pkg::OFF_CTRL, 32'h2);
    cyc(LONG);
    rdc(lcrs_pkg::OFF_STATUS, 32'h8, "manual loop-down");
    wr(lcrs_pkg::OFF_CTRL, 32'h3);
    rdc(lcrs_pkg::OFF_STATUS, 32'h0, "auto clears flag");
    cyc(LONG);
    rdc(lcrs_pkg::OFF_STATUS, 32'h0, "auto ignores loop-down");
    $display("test manual done");

    code <= 2'h0;
    wr(lcrs_pkg::OFF_IRQ_EN, 32'h8);
    acc(1'b0, lcrs_pkg::OFF_IRQ_STAT, 32'h0);
    cyc(2);
    chk(irq, 1'b0, "auto idle irq");
    code <= 2'h1;
    cyc(LONG);
    rdc(lcrs_pkg::OFF_STATUS, 32'h18, "auto loop-up");
    chk(rlb, 1'b1, "loopback on");
    chk(irq, 1'b1, "auto rise irq");
    rdc(lcrs_pkg::OFF_IRQ_STAT, 32'h8, "auto rise");
    code <= 2'h0;
    cyc(LONG);
    rdc(lcrs_pkg::OFF_STATUS, 32'h18, "flag holds");
    chk(rlb, 1'b1, "loopback holds");
    code <= 2'h2;
    cyc(LONG);
    rdc(lcrs_pkg::OFF_STATUS, 32'h0, "auto loop-down");
    chk(rlb, 1'b0, "loopback off");
    chk(irq, 1'b1, "auto fall irq");
    rdc(lcrs_pkg::OFF_IRQ_STAT, 32'h8, "auto fall");
    $display("test auto done");

    wr(lcrs_pkg::OFF_CTRL, 32'h0);
    code <= 2'h1;
    cyc(LONG);
    rdc(lcrs_pkg::OFF_STATUS, 32'h0, "off mode");
    chk(rlb, 1'b0, "off no loopback");
    rdc(lcrs_pkg::OFF_IRQ_STAT, 32'h0, "off no event");
    al[0] <= 1'b1;
    cyc(3);
    wr(lcrs_pkg::OFF_IRQ_STAT, 32'h1);
    rdc(lcrs_pkg::OFF_IRQ_STAT, 32'h0, "write one clears");
    $display("test off done");
    give_verdict();
  end

  initial begin
    cyc(20000);
    err_count++;
    $display("Error at %0t: watchdog expired", $time);
    give_verdict();
  end
endmodule
